// file: shared/rlsm_pkg.sv
`default_nettype none
package rlsm_pkg;
	localparam int NUM_INST = 6;
	localparam int NUM_OUT = 3;
	localparam logic [2:0] INST_LIMIT = 3'h6;
	// Command codes on the decoded command port
	localparam logic [3:0] OP_SETTING = 4'h0;
	localparam logic [3:0] OP_LOCK_CLAIM = 4'h1;
	localparam logic [3:0] OP_LOCK_QUERY = 4'h2;
	localparam logic [3:0] OP_LIM_LOG_RD = 4'h3;
	localparam logic [3:0] OP_LIM_MASK_WR = 4'h4;
	localparam logic [3:0] OP_LIM_MASK_RD = 4'h5;
	localparam logic [3:0] OP_STD_LOG_RD = 4'h6;
	localparam logic [3:0] OP_STD_MASK_WR = 4'h7;
	localparam logic [3:0] OP_STD_MASK_RD = 4'h8;
	localparam logic [3:0] OP_FAULT_RD = 4'h9;
	localparam logic [3:0] OP_STB_RD = 4'ha;
	localparam logic [3:0] OP_SRQ_MASK_WR = 4'hb;
	localparam logic [3:0] OP_SRQ_MASK_RD = 4'hc;
	localparam logic [3:0] OP_PPOLL_MASK_WR = 4'hd;
	localparam logic [3:0] OP_PPOLL_MASK_RD = 4'he;
	localparam logic [3:0] OP_IST_RD = 4'hf;
	// Lock command arguments and query answers
	localparam logic [7:0] LOCK_ARG_CLAIM = 8'h01;
	localparam logic [7:0] LOCK_ARG_RELEASE = 8'h00;
	localparam logic [7:0] LOCK_ANS_OTHER = 8'hff;
	localparam logic [7:0] LOCK_ANS_FREE = 8'h00;
	localparam logic [7:0] LOCK_ANS_MINE = 8'h01;
	// Privilege codes, two bits per instance
	localparam logic [1:0] PRIV_FULL = 2'h0;
	localparam logic [1:0] PRIV_READ_ONLY = 2'h1;
	localparam logic [1:0] PRIV_NONE = 2'h2;
	// Limit event log bit positions
	localparam int LIM_CV_BIT = 0;
	localparam int LIM_CC_BIT = 1;
	localparam int LIM_OVP_BIT = 2;
	localparam int LIM_OCP_BIT = 3;
	localparam int LIM_HARD_BIT = 6;
	localparam logic [7:0] LIM_USED_BITS = 8'h4f;
	// Standard event log and status byte
	localparam int STD_EXEC_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_MSS_BIT = 6;
	localparam logic [7:0] STB_SUMMARY_MASK = 8'hbf;
	localparam logic [7:0] FAULT_ACCESS_DENIED = 8'hc8;
	// Values after reset
	localparam logic [7:0] STD_LOG_RESET = 8'h80;
	localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : rlsm_pkg
`default_nettype wire

// file: design/rlsm_inst_status.sv
`timescale 1ns/1ns
`default_nettype none
module rlsm_inst_status (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_sel,
	input wire logic i_deny,
	input wire logic [3:0] i_op,
	input wire logic [7:0] i_arg,
	input wire logic [1:0] i_out_sel,
	input wire logic [23:0] i_events,
	output logic [7:0] o_rd_data,
	output logic o_mss,
	output logic o_ist
);
	logic [7:0] lim_log_reg [3];
	logic [7:0] lim_mask_reg [3];
	logic [7:0] std_log_reg;
	logic [7:0] std_mask_reg;
	logic [7:0] fault_reg;
	logic [7:0] srq_mask_reg;
	logic [7:0] ppoll_mask_reg;
	logic [2:0] lim_sum;
	logic [7:0] std_log_next;
	logic [7:0] fault_next;
	logic [7:0] stb_base;
	logic [7:0] stb;
	logic [7:0] lim_rd;
	logic [7:0] mask_rd;
	logic out_ok;
	localparam logic [7:0] BYTE_RESET_W = rlsm_pkg::BYTE_RESET;

	assign out_ok = (i_out_sel < 2'h3);
	assign lim_rd = out_ok ? lim_log_reg[i_out_sel] : BYTE_RESET_W;
	assign mask_rd = out_ok ? lim_mask_reg[i_out_sel] : BYTE_RESET_W;

	genvar g;
	generate
		for (g = 0; g < rlsm_pkg::NUM_OUT; g++) begin : g_out
			logic rd_clr;
			logic mask_wr;
			logic [7:0] ev;
			assign rd_clr = i_sel && i_op == rlsm_pkg::OP_LIM_LOG_RD &&
				i_out_sel == 2'(g);
			assign mask_wr = i_sel && i_op == rlsm_pkg::OP_LIM_MASK_WR &&
				i_out_sel == 2'(g);
			// Reserved positions can never latch
			assign ev = i_events[g*8 +: 8] & rlsm_pkg::LIM_USED_BITS;
			// A summary per output through its own mask
			assign lim_sum[g] = |(lim_log_reg[g] & lim_mask_reg[g]);
			always_ff @(posedge i_clock or negedge i_rst_b) begin
				if (!i_rst_b) begin
					lim_log_reg[g] <= rlsm_pkg::BYTE_RESET;
					lim_mask_reg[g] <= rlsm_pkg::BYTE_RESET;
				end else begin
					// Set wins over read-clear so no trip is lost
					lim_log_reg[g] <= rd_clr ? ev : (lim_log_reg[g] | ev);
					if (mask_wr) begin
						lim_mask_reg[g] <= i_arg;
					end
				end
			end
		end
	endgenerate

	assign std_log_next = ((i_sel && i_op == rlsm_pkg::OP_STD_LOG_RD) ?
		BYTE_RESET_W : std_log_reg) |
		{3'h0, i_deny, 4'h0};
	assign fault_next = i_deny ? rlsm_pkg::FAULT_ACCESS_DENIED :
		(i_sel && i_op == rlsm_pkg::OP_FAULT_RD) ? BYTE_RESET_W :
		fault_reg;
	assign stb_base = {2'h0, |(std_log_reg & std_mask_reg), 2'h0,
		lim_sum};
	assign o_mss = |(stb_base & srq_mask_reg & rlsm_pkg::STB_SUMMARY_MASK);
	assign stb = stb_base | {1'h0, o_mss, 6'h0};
	assign o_ist = |(stb & ppoll_mask_reg);

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			std_log_reg <= rlsm_pkg::STD_LOG_RESET;
			std_mask_reg <= rlsm_pkg::BYTE_RESET;
			fault_reg <= rlsm_pkg::BYTE_RESET;
			srq_mask_reg <= rlsm_pkg::BYTE_RESET;
			ppoll_mask_reg <= rlsm_pkg::BYTE_RESET;
		end else begin
			std_log_reg <= std_log_next;
			fault_reg <= fault_next;
			if (i_sel && i_op == rlsm_pkg::OP_STD_MASK_WR) begin
				std_mask_reg <= i_arg;
			end
			if (i_sel && i_op == rlsm_pkg::OP_SRQ_MASK_WR) begin
				srq_mask_reg <= i_arg;
			end
			if (i_sel && i_op == rlsm_pkg::OP_PPOLL_MASK_WR) begin
				ppoll_mask_reg <= i_arg;
			end
		end
	end

	always_comb begin
		unique case (i_op)
			rlsm_pkg::OP_LIM_LOG_RD: o_rd_data = lim_rd;
			rlsm_pkg::OP_LIM_MASK_RD: o_rd_data = mask_rd;
			rlsm_pkg::OP_STD_LOG_RD: o_rd_data = std_log_reg;
			rlsm_pkg::OP_STD_MASK_RD: o_rd_data = std_mask_reg;
			rlsm_pkg::OP_FAULT_RD: o_rd_data = fault_reg;
			rlsm_pkg::OP_STB_RD: o_rd_data = stb;
			rlsm_pkg::OP_SRQ_MASK_RD: o_rd_data = srq_mask_reg;
			rlsm_pkg::OP_PPOLL_MASK_RD: o_rd_data = ppoll_mask_reg;
			rlsm_pkg::OP_IST_RD: o_rd_data = {7'h0, o_ist};
			default: o_rd_data = BYTE_RESET_W;
		endcase
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	chk_deny_fault_load: assert property (
		i_deny |=> fault_reg == rlsm_pkg::FAULT_ACCESS_DENIED &&
		std_log_reg[rlsm_pkg::STD_EXEC_BIT])
		else $error("denied command did not load fault code");
	chk_log_read_clear: assert property (
		i_sel && i_op == rlsm_pkg::OP_LIM_LOG_RD && i_out_sel == 2'h0 &&
		(i_events[7:0] & rlsm_pkg::LIM_USED_BITS) == 8'h00
		|=> lim_log_reg[0] == 8'h00)
		else $error("limit log not cleared by its read");
	chk_event_latch_hold: assert property (
		i_events[rlsm_pkg::LIM_OCP_BIT] && !(i_sel &&
		i_op == rlsm_pkg::OP_LIM_LOG_RD && i_out_sel == 2'h0)
		|=> lim_log_reg[0][rlsm_pkg::LIM_OCP_BIT] ##1
		(lim_log_reg[0][rlsm_pkg::LIM_OCP_BIT] || $past(i_sel)))
		else $error("trip bit was not held");
endmodule : rlsm_inst_status
`default_nettype wire

// file: design/rlsm_top.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Lock claim with argument 1 gives that instance exclusive settings control.
// - Release with argument 0 works only from the owner; others are ignored.
// - Lock query answers -1 other owner, 0 free, 1 own lock.
// - Unprivileged setting change is blocked, sets event bit 4, fault code 200.
// - Owner disconnect or local key drops the lock at once.
// - All six instances take commands at all times, no selection needed.
// - Each instance keeps its own status and error register set.
// - Per-instance privilege full, read only or none; restricted ops denied.
// - Output limit summary set when log and mask share a set bit.
// - Reading a limit event log returns it and clears it.
// - Limit event mask is written by command and reads back unchanged.
// - Bit 6 logs a latched hard fault trip.
// - Bit 3 logs over-current trip, bit 2 over-voltage trip.
// - Bit 1 logs entry to current limit, bit 0 to voltage limit.
// - Limit log bits 7, 5 and 4 never receive an event.
// - Status byte formed through three limit masks and standard event mask.
// - Service request and parallel poll masks select status byte bits.
// - Status byte bits 0, 1, 2 summarise outputs 1, 2, 3.
// - Fault code clears on read and is zero after reset.
// - Status bit with its request mask bit raises the request summary.
module rlsm_top (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_cmd_valid,
	input wire logic [2:0] i_cmd_inst,
	input wire logic [3:0] i_cmd_op,
	input wire logic [7:0] i_cmd_arg,
	input wire logic [1:0] i_cmd_out,
	input wire logic [11:0] i_inst_priv,
	input wire logic [5:0] i_disconnect,
	input wire logic i_local_key,
	input wire logic [2:0] i_cv_mode,
	input wire logic [2:0] i_cc_mode,
	input wire logic [2:0] i_ovp_trip,
	input wire logic [2:0] i_ocp_trip,
	input wire logic [2:0] i_hard_fault,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	output logic o_rsp_refused,
	output logic o_setting_apply,
	output logic o_lock_held,
	output logic [2:0] o_lock_owner,
	output logic [5:0] o_service_request,
	output logic [5:0] o_ppoll_ist
);
	function automatic logic changes_state(input logic [3:0] op,
		input logic [7:0] arg);
		changes_state = op == rlsm_pkg::OP_SETTING ||
			(op == rlsm_pkg::OP_LOCK_CLAIM && arg == rlsm_pkg::LOCK_ARG_CLAIM);
	endfunction : changes_state

	function automatic logic is_lock_op(input logic [3:0] op);
		is_lock_op = op == rlsm_pkg::OP_LOCK_CLAIM ||
			op == rlsm_pkg::OP_LOCK_QUERY;
	endfunction : is_lock_op

	logic rsp_valid_reg;
	logic [7:0] rsp_data_reg;
	logic rsp_refused_reg;
	logic apply_reg;
	logic lock_held_reg;
	logic [2:0] lock_owner_reg;
	logic [5:0] srq_reg;
	logic [5:0] ist_reg;
	logic [2:0] cv_prev_reg;
	logic [2:0] cc_prev_reg;
	logic [2:0] ovp_prev_reg;
	logic [2:0] ocp_prev_reg;
	logic [2:0] hard_prev_reg;
	logic lock_held_next;
	logic [2:0] lock_owner_next;
	logic [7:0] rsp_data_next;

	wire take_w = i_cmd_valid && i_cmd_inst < rlsm_pkg::INST_LIMIT;
	wire [1:0] priv_w = i_inst_priv[{i_cmd_inst, 1'b0} +: 2];
	wire own_w = lock_held_reg && lock_owner_reg == i_cmd_inst;
	wire foreign_w = lock_held_reg && lock_owner_reg != i_cmd_inst;
	wire change_w = changes_state(i_cmd_op, i_cmd_arg);
	// No access refuses every command; read only refuses changes
	wire deny_w = take_w && (priv_w == rlsm_pkg::PRIV_NONE ||
		(change_w && (priv_w == rlsm_pkg::PRIV_READ_ONLY || foreign_w)));
	wire ok_w = take_w && !deny_w;
	wire claim_w = ok_w && i_cmd_op == rlsm_pkg::OP_LOCK_CLAIM &&
		i_cmd_arg == rlsm_pkg::LOCK_ARG_CLAIM;
	// Release from a non-owner falls through and changes nothing
	wire release_w = ok_w && i_cmd_op == rlsm_pkg::OP_LOCK_CLAIM &&
		i_cmd_arg == rlsm_pkg::LOCK_ARG_RELEASE && own_w;
	wire drop_w = i_local_key ||
		(lock_held_reg && i_disconnect[lock_owner_reg]);
	wire [7:0] lock_ans_w = !lock_held_reg ? rlsm_pkg::LOCK_ANS_FREE :
		own_w ? rlsm_pkg::LOCK_ANS_MINE : rlsm_pkg::LOCK_ANS_OTHER;

	// Drop beats a claim in the same cycle: the key must win
	assign lock_held_next = drop_w ? 1'b0 : claim_w ? 1'b1 :
		release_w ? 1'b0 : lock_held_reg;
	assign lock_owner_next = claim_w ? i_cmd_inst : lock_owner_reg;

	// Rising edges only, so a held limit condition logs once
	wire [2:0] cv_rise = i_cv_mode & ~cv_prev_reg;
	wire [2:0] cc_rise = i_cc_mode & ~cc_prev_reg;
	wire [2:0] ovp_rise = i_ovp_trip & ~ovp_prev_reg;
	wire [2:0] ocp_rise = i_ocp_trip & ~ocp_prev_reg;
	wire [2:0] hard_rise = i_hard_fault & ~hard_prev_reg;
	logic [23:0] events_w;
	logic [7:0] inst_rd [6];
	logic [5:0] inst_mss;
	logic [5:0] inst_ist;

	genvar g;
	generate
		for (g = 0; g < rlsm_pkg::NUM_OUT; g++) begin : g_ev
			always_comb begin
				events_w[g*8 +: 8] = 8'h00;
				events_w[g*8 + rlsm_pkg::LIM_CV_BIT] = cv_rise[g];
				events_w[g*8 + rlsm_pkg::LIM_CC_BIT] = cc_rise[g];
				events_w[g*8 + rlsm_pkg::LIM_OVP_BIT] = ovp_rise[g];
				events_w[g*8 + rlsm_pkg::LIM_OCP_BIT] = ocp_rise[g];
				events_w[g*8 + rlsm_pkg::LIM_HARD_BIT] = hard_rise[g];
			end
		end
		// One independent status set per interface instance
		for (g = 0; g < rlsm_pkg::NUM_INST; g++) begin : g_inst
			wire hit_w = i_cmd_inst == 3'(g);
			rlsm_inst_status u_status (
				.i_clock(i_clock),
				.i_rst_b(i_rst_b),
				.i_sel(ok_w && hit_w),
				.i_deny(deny_w && hit_w),
				.i_op(i_cmd_op),
				.i_arg(i_cmd_arg),
				.i_out_sel(i_cmd_out),
				.i_events(events_w),
				.o_rd_data(inst_rd[g]),
				.o_mss(inst_mss[g]),
				.o_ist(inst_ist[g])
			);
		end
	endgenerate

	assign rsp_data_next = !ok_w ? 8'h00 :
		i_cmd_op == rlsm_pkg::OP_LOCK_QUERY ? lock_ans_w :
		is_lock_op(i_cmd_op) ? 8'h00 : inst_rd[i_cmd_inst];

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lock_held_reg <= 1'b0;
			lock_owner_reg <= 3'h0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= 8'h00;
			rsp_refused_reg <= 1'b0;
			apply_reg <= 1'b0;
		end else begin
			lock_held_reg <= lock_held_next;
			lock_owner_reg <= lock_owner_next;
			rsp_valid_reg <= take_w;
			rsp_data_reg <= rsp_data_next;
			rsp_refused_reg <= deny_w;
			apply_reg <= ok_w && i_cmd_op == rlsm_pkg::OP_SETTING;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cv_prev_reg <= 3'h0;
			cc_prev_reg <= 3'h0;
			ovp_prev_reg <= 3'h0;
			ocp_prev_reg <= 3'h0;
			hard_prev_reg <= 3'h0;
			srq_reg <= 6'h00;
			ist_reg <= 6'h00;
		end else begin
			cv_prev_reg <= i_cv_mode;
			cc_prev_reg <= i_cc_mode;
			ovp_prev_reg <= i_ovp_trip;
			ocp_prev_reg <= i_ocp_trip;
			hard_prev_reg <= i_hard_fault;
			srq_reg <= inst_mss;
			ist_reg <= inst_ist;
		end
	end

	assign o_rsp_valid = rsp_valid_reg;
	assign o_rsp_data = rsp_data_reg;
	assign o_rsp_refused = rsp_refused_reg;
	assign o_setting_apply = apply_reg;
	assign o_lock_held = lock_held_reg;
	assign o_lock_owner = lock_owner_reg;
	assign o_service_request = srq_reg;
	assign o_ppoll_ist = ist_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	chk_lock_grant: assert property (
		take_w && i_cmd_op == rlsm_pkg::OP_LOCK_CLAIM && i_cmd_arg == 8'h01 &&
		!lock_held_reg && priv_w == rlsm_pkg::PRIV_FULL && !i_local_key
		|=> o_lock_held && o_lock_owner == $past(i_cmd_inst))
		else $error("lock claim on free lock not granted");
	chk_foreign_release: assert property (
		take_w && i_cmd_op == rlsm_pkg::OP_LOCK_CLAIM && i_cmd_arg == 8'h00 &&
		foreign_w && !drop_w
		|=> o_lock_held && $stable(o_lock_owner))
		else $error("foreign release changed the lock");
	chk_query_answer: assert property (
		take_w && i_cmd_op == rlsm_pkg::OP_LOCK_QUERY &&
		priv_w != rlsm_pkg::PRIV_NONE
		|=> o_rsp_valid && o_rsp_data == (!$past(lock_held_reg) ? 8'h00 :
		$past(lock_owner_reg) == $past(i_cmd_inst) ? 8'h01 : 8'hff))
		else $error("lock query answered wrongly");
	chk_denied_blocked: assert property (
		take_w && i_cmd_op == rlsm_pkg::OP_SETTING && foreign_w
		|=> o_rsp_refused && !o_setting_apply)
		else $error("change from non-owner took effect");
	chk_local_drop: assert property (
		i_local_key |=> !o_lock_held)
		else $error("local key did not drop the lock");
	chk_any_instance: assert property (
		take_w && i_cmd_op == rlsm_pkg::OP_SETTING && !lock_held_reg &&
		priv_w == rlsm_pkg::PRIV_FULL |=> o_setting_apply ##1
		(!o_setting_apply ||
		$past(ok_w && i_cmd_op == rlsm_pkg::OP_SETTING)))
		else $error("free instance change not applied once");
	chk_read_only: assert property (
		take_w && priv_w == rlsm_pkg::PRIV_READ_ONLY && change_w && !drop_w
		|=> o_rsp_refused && $stable(o_lock_held))
		else $error("read-only instance was not refused");
	chk_ro_query_ok: assert property (
		take_w && priv_w == rlsm_pkg::PRIV_READ_ONLY && !change_w
		|=> !o_rsp_refused)
		else $error("read-only instance refused a read");
	chk_no_access: assert property (
		take_w && priv_w == rlsm_pkg::PRIV_NONE |=> o_rsp_refused)
		else $error("no-access instance was not refused");
	chk_srq_follow: assert property (
		inst_mss[0] |=> o_service_request[0])
		else $error("request summary not raised");

	chk_owner_release: assert property (
		release_w |=> !o_lock_held)
		else $error("owner release kept the lock");
	chk_link_drop: assert property (
		lock_held_reg && i_disconnect[lock_owner_reg] |=> !o_lock_held)
		else $error("owner disconnect did not drop the lock");
	chk_drop_beats_claim: assert property (
		claim_w && drop_w |=> !o_lock_held)
		else $error("claim survived a lock drop");
	chk_lock_keep: assert property (
		lock_held_reg && !drop_w && !release_w
		|=> o_lock_held && $stable(o_lock_owner))
		else $error("held lock changed without cause");
	chk_owner_stable: assert property (
		!claim_w |=> $stable(o_lock_owner))
		else $error("lock owner moved without a claim");
	chk_claim_refused: assert property (
		take_w && i_cmd_op == rlsm_pkg::OP_LOCK_CLAIM &&
		i_cmd_arg == rlsm_pkg::LOCK_ARG_CLAIM && foreign_w
		|=> o_rsp_refused && $stable(o_lock_owner))
		else $error("claim against a foreign lock was not refused");

	chk_answer_next: assert property (
		take_w |=> o_rsp_valid)
		else $error("taken command got no answer");
	chk_idle_quiet: assert property (
		!take_w |=> !o_rsp_valid && !o_rsp_refused && !o_setting_apply &&
		o_rsp_data == 8'h00)
		else $error("answer without a taken command");
	chk_refused_reply: assert property (
		o_rsp_refused |-> o_rsp_valid && o_rsp_data == 8'h00 &&
		!o_setting_apply)
		else $error("refused command gave data or took effect");

	// One register stage between each summary and its pin
	generate
		for (g = 0; g < rlsm_pkg::NUM_INST; g++) begin : g_chk
			chk_srq_each: assert property (@(posedge i_clock)
				disable iff (!i_rst_b) inst_mss[g] |=> o_service_request[g])
				else $error("request summary pin did not rise");
			chk_srq_quiet: assert property (@(posedge i_clock)
				disable iff (!i_rst_b) !inst_mss[g] |=> !o_service_request[g])
				else $error("request summary pin stuck high");
			chk_ist_each: assert property (@(posedge i_clock)
				disable iff (!i_rst_b) inst_ist[g] |=> o_ppoll_ist[g])
				else $error("parallel poll pin did not rise");
			chk_ist_quiet: assert property (@(posedge i_clock)
				disable iff (!i_rst_b) !inst_ist[g] |=> !o_ppoll_ist[g])
				else $error("parallel poll pin stuck high");
		end
	endgenerate

	cov_lock_taken: cover property (claim_w ##[1:20] release_w);
	cov_denied_change: cover property (deny_w && change_w);
	cov_disconnect_drop: cover property (lock_held_reg && drop_w &&
		!i_local_key);
	cov_service_req: cover property ($rose(o_service_request[0]));
	cov_query_other: cover property (take_w &&
		i_cmd_op == rlsm_pkg::OP_LOCK_QUERY && foreign_w);
endmodule : rlsm_top
`default_nettype wire

// file: testbench/rlsm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rlsm_host_model (
	input wire logic i_clock,
	input wire logic i_rsp_valid,
	input wire logic [7:0] i_rsp_data,
	input wire logic i_rsp_refused,
	output logic o_cmd_valid,
	output logic [2:0] o_cmd_inst,
	output logic [3:0] o_cmd_op,
	output logic [7:0] o_cmd_arg,
	output logic [1:0] o_cmd_out
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_inst = 3'h7;
		o_cmd_op = 4'h0;
		o_cmd_arg = 8'h00;
		o_cmd_out = 2'h0;
	end
	// One command, then idle lines inverted so stale values never match
	// Logs are read by direct query, not through the summary
	task automatic send(input logic [2:0] inst, input logic [3:0] op,
		input logic [7:0] arg, input logic [1:0] outn,
		output logic [7:0] data, output logic refused, output logic valid);
		@(posedge i_clock);
		o_cmd_valid <= 1'b1;
		o_cmd_inst <= inst;
		o_cmd_op <= op;
		o_cmd_arg <= arg;
		o_cmd_out <= outn;
		@(posedge i_clock);
		o_cmd_valid <= 1'b0;
		o_cmd_inst <= ~inst;
		o_cmd_op <= ~op;
		o_cmd_arg <= ~arg;
		o_cmd_out <= ~outn;
		#1;
		data = i_rsp_data;
		refused = i_rsp_refused;
		valid = i_rsp_valid;
	endtask : send
endmodule : rlsm_host_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic i_clock, i_rst_b, c_valid, i_local_key, rf, rv;
	logic [2:0] c_inst, i_cv_mode, i_cc_mode, i_ovp_trip, i_ocp_trip;
	logic [2:0] i_hard_fault, o_lock_owner;
	logic [3:0] c_op;
	logic [7:0] c_arg, o_rsp_data, rd;
	logic [1:0] c_out;
	logic [11:0] i_inst_priv;
	logic [5:0] i_disconnect, o_service_request, o_ppoll_ist;
	logic o_rsp_valid, o_rsp_refused, o_setting_apply, o_lock_held;
	int n_fail = 0;
	int n_checks = 0;
	rlsm_top u_rlsm_top (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_cmd_valid(c_valid), .i_cmd_inst(c_inst), .i_cmd_op(c_op),
		.i_cmd_arg(c_arg), .i_cmd_out(c_out), .i_inst_priv(i_inst_priv),
		.i_disconnect(i_disconnect), .i_local_key(i_local_key),
		.i_cv_mode(i_cv_mode), .i_cc_mode(i_cc_mode),
		.i_ovp_trip(i_ovp_trip), .i_ocp_trip(i_ocp_trip),
		.i_hard_fault(i_hard_fault), .o_rsp_valid(o_rsp_valid),
		.o_rsp_data(o_rsp_data), .o_rsp_refused(o_rsp_refused),
		.o_setting_apply(o_setting_apply), .o_lock_held(o_lock_held),
		.o_lock_owner(o_lock_owner), .o_service_request(o_service_request),
		.o_ppoll_ist(o_ppoll_ist));
	rlsm_host_model u_rlsm_host_model (.i_clock(i_clock),
		.i_rsp_valid(o_rsp_valid), .i_rsp_data(o_rsp_data),
		.i_rsp_refused(o_rsp_refused), .o_cmd_valid(c_valid),
		.o_cmd_inst(c_inst), .o_cmd_op(c_op), .o_cmd_arg(c_arg),
		.o_cmd_out(c_out));
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic close_out;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [2:0] i, input logic [3:0] op,
		input logic [7:0] arg, input logic [1:0] n);
		u_rlsm_host_model.send(i, op, arg, n, rd, rf, rv);
		chk({7'h00, rv}, 8'h01, "no reply");
	endtask : cmd
	task automatic q(input logic [2:0] i, input logic [3:0] op,
		input logic [7:0] arg, input logic [1:0] n, input logic [7:0] exp);
		cmd(i, op, arg, n);
		chk(rd, exp, "reply");
	endtask : q
	task automatic pulse(input int k, input int n);
		logic [2:0] b;
		b = 3'h1 << n;
		@(posedge i_clock);
		case (k)
			0: i_cv_mode <= b;
			1: i_cc_mode <= b;
			2: i_ovp_trip <= b;
			3: i_ocp_trip <= b;
			default: i_hard_fault <= b;
		endcase
		@(posedge i_clock);
		{i_cv_mode, i_cc_mode, i_ovp_trip, i_ocp_trip, i_hard_fault} <= 15'h0;
	endtask : pulse
	task automatic t_reset;
		q(0, rlsm_pkg::OP_STD_LOG_RD, 0, 0, 8'h80);
		q(0, rlsm_pkg::OP_STD_LOG_RD, 0, 0, 8'h00);
		q(3, rlsm_pkg::OP_FAULT_RD, 0, 0, 8'h00);
		q(1, rlsm_pkg::OP_LOCK_QUERY, 0, 0, rlsm_pkg::LOCK_ANS_FREE);
		q(2, rlsm_pkg::OP_LIM_MASK_RD, 0, 2, 8'h00);
		q(5, rlsm_pkg::OP_LIM_LOG_RD, 0, 1, 8'h00);
	endtask : t_reset
	task automatic t_lock;
		cmd(1, rlsm_pkg::OP_LOCK_CLAIM, rlsm_pkg::LOCK_ARG_CLAIM, 0);
		chk({7'h00, o_lock_held}, 8'h01, "held");
		chk({5'h00, o_lock_owner}, 8'h01, "owner");
		q(1, rlsm_pkg::OP_LOCK_QUERY, 0, 0, rlsm_pkg::LOCK_ANS_MINE);
		q(4, rlsm_pkg::OP_LOCK_QUERY, 0, 0, rlsm_pkg::LOCK_ANS_OTHER);
		cmd(2, rlsm_pkg::OP_SETTING, 0, 0);
		chk({7'h00, rf}, 8'h01, "refused");
		chk({7'h00, o_setting_apply}, 8'h00, "applied");
		q(2, rlsm_pkg::OP_STD_LOG_RD, 0, 0, 8'h90);
		q(2, rlsm_pkg::OP_FAULT_RD, 0, 0, 8'hc8);
		q(2, rlsm_pkg::OP_FAULT_RD, 0, 0, 8'h00);
		q(0, rlsm_pkg::OP_FAULT_RD, 0, 0, 8'h00);
		cmd(2, rlsm_pkg::OP_LOCK_CLAIM, rlsm_pkg::LOCK_ARG_RELEASE, 0);
		q(1, rlsm_pkg::OP_LOCK_QUERY, 0, 0, rlsm_pkg::LOCK_ANS_MINE);
		cmd(1, rlsm_pkg::OP_SETTING, 0, 0);
		chk({7'h00, o_setting_apply}, 8'h01, "owner apply");
		cmd(1, rlsm_pkg::OP_LOCK_CLAIM, rlsm_pkg::LOCK_ARG_RELEASE, 0);
		q(2, rlsm_pkg::OP_LOCK_QUERY, 0, 0, rlsm_pkg::LOCK_ANS_FREE);
	endtask : t_lock
	task automatic t_drop;
		cmd(3, rlsm_pkg::OP_LOCK_CLAIM, rlsm_pkg::LOCK_ARG_CLAIM, 0);
		@(posedge i_clock);
		i_local_key <= 1'b1;
		@(posedge i_clock);
		i_local_key <= 1'b0;
		#1 chk({7'h00, o_lock_held}, 8'h00, "key drop");
		cmd(4, rlsm_pkg::OP_LOCK_CLAIM, rlsm_pkg::LOCK_ARG_CLAIM, 0);
		@(posedge i_clock);
		i_disconnect <= 6'h10;
		@(posedge i_clock);
		i_disconnect <= 6'h00;
		#1 chk({7'h00, o_lock_held}, 8'h00, "link drop");
	endtask : t_drop
	task automatic t_priv;
		for (int i = 0; i < 6; i++) begin
			cmd(i[2:0], rlsm_pkg::OP_SETTING, 0, 0);
			chk({7'h00, o_setting_apply}, 8'h01, "apply");
		end
		// Socket A no access, socket B read only
		@(posedge i_clock);
		i_inst_priv <= 12'h600;
		q(5, rlsm_pkg::OP_LOCK_QUERY, 0, 0, rlsm_pkg::LOCK_ANS_FREE);
		cmd(5, rlsm_pkg::OP_SETTING, 0, 0);
		chk({7'h00, rf}, 8'h01, "read only");
		cmd(5, rlsm_pkg::OP_LOCK_CLAIM, rlsm_pkg::LOCK_ARG_CLAIM, 0);
		chk({7'h00, rf}, 8'h01, "ro claim");
		cmd(4, rlsm_pkg::OP_LOCK_QUERY, 0, 0);
		chk({7'h00, rf}, 8'h01, "no access");
		@(posedge i_clock);
		i_inst_priv <= 12'h000;
	endtask : t_priv
	task automatic t_limits;
		logic [7:0] pos [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40};
		for (int n = 0; n < 3; n++) begin
			cmd(0, rlsm_pkg::OP_LIM_MASK_WR, 8'ha5, n[1:0]);
			q(0, rlsm_pkg::OP_LIM_MASK_RD, 0, n[1:0], 8'ha5);
			// Condition is gone before the read: the bit must have latched
			for (int k = 0; k < 5; k++) begin
				pulse(k, n);
				q(0, rlsm_pkg::OP_LIM_LOG_RD, 0, n[1:0], pos[k]);
				q(0, rlsm_pkg::OP_LIM_LOG_RD, 0, n[1:0], 8'h00);
			end
			cmd(0, rlsm_pkg::OP_LIM_MASK_WR, 8'h08, n[1:0]);
			cmd(0, rlsm_pkg::OP_SRQ_MASK_WR, 8'h01 << n, 0);
			cmd(0, rlsm_pkg::OP_PPOLL_MASK_WR, 8'h01 << n, 0);
			pulse(0, n);
			q(0, rlsm_pkg::OP_STB_RD, 0, 0, 8'h00);
			chk({7'h00, o_service_request[0]}, 8'h00, "srq off");
			pulse(3, n);
			q(0, rlsm_pkg::OP_STB_RD, 0, 0, (8'h01 << n) | 8'h40);
			chk({7'h00, o_service_request[0]}, 8'h01, "srq on");
			chk({7'h00, o_ppoll_ist[0]}, 8'h01, "ist on");
			q(0, rlsm_pkg::OP_IST_RD, 0, 0, 8'h01);
			q(0, rlsm_pkg::OP_SRQ_MASK_RD, 0, 0, 8'h01 << n);
			q(0, rlsm_pkg::OP_PPOLL_MASK_RD, 0, 0, 8'h01 << n);
			q(0, rlsm_pkg::OP_LIM_LOG_RD, 0, n[1:0], 8'h09);
			q(0, rlsm_pkg::OP_STB_RD, 0, 0, 8'h00);
			chk({7'h00, o_service_request[0]}, 8'h00, "srq clear");
			chk({7'h00, o_ppoll_ist[0]}, 8'h00, "ist clear");
		end
		cmd(3, rlsm_pkg::OP_STD_MASK_WR, 8'h80, 0);
		q(3, rlsm_pkg::OP_STB_RD, 0, 0, 8'h20);
		q(3, rlsm_pkg::OP_STD_MASK_RD, 0, 0, 8'h80);
	endtask : t_limits
	initial begin
		repeat (20000) @(posedge i_clock);
		n_fail++;
		close_out();
	end
	initial begin
		i_rst_b = 1'b0;
		i_inst_priv = 12'h000;
		i_disconnect = 6'h00;
		i_local_key = 1'b0;
		{i_cv_mode, i_cc_mode, i_ovp_trip, i_ocp_trip, i_hard_fault} = 15'h0;
		repeat (2) @(posedge i_clock);
		i_rst_b <= 1'b1;
		t_reset();
		t_lock();
		t_drop();
		t_priv();
		t_limits();
		close_out();
	end
endmodule : testbench
`default_nettype wire
